// *** hdl/prc_map.svh ***
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

// Register offsets on the serial register port
`define PRC_USER_CONTROL_ADDR 7'h6a
`define PRC_POWER_CONTROL_ONE_ADDR 7'h6b

// user_control field positions
`define PRC_UC_BUF_EN_BIT 6
`define PRC_UC_BUF_CLR_BIT 2
`define PRC_UC_PATH_CLR_BIT 0
`define PRC_UC_RESERVED_MASK 8'hba

// Reset values
`define PRC_UC_RESET 8'h00
`define PRC_PWR_RESET 8'h01

// timebase_source_pick codes
`define PRC_CLK_OSC_A 3'h0
`define PRC_CLK_AUTO 3'h1
`define PRC_CLK_OSC_B 3'h6
`define PRC_CLK_STOP 3'h7

// Timing, in picoseconds, and the counts derived from them
`define PRC_MCLK_PERIOD_PS 5000
`define PRC_OSC_PERIOD_PS 50000
`define PRC_OSC_DIV (`PRC_OSC_PERIOD_PS / `PRC_MCLK_PERIOD_PS)
`define PRC_BASE_PERIOD_PS 1000000000
`define PRC_BASE_OSC_TICKS (`PRC_BASE_PERIOD_PS / `PRC_OSC_PERIOD_PS)
`define PRC_DEV_RST_LAST 2'h1

`endif

// *** hdl/prc_pkg.sv ***
package prc_pkg;

  typedef enum logic [1:0] {
    PM_AWAKE = 2'b00,
    PM_SLEEP = 2'b01,
    PM_DOZE = 2'b10,
    PM_WAKE = 2'b11
  } prc_pm_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } prc_req_type;

  typedef struct packed {
    logic dev_reset;
    logic sleep;
    logic cycle;
    logic gyro_standby;
    logic thermometer_off;
    logic [2:0] timebase_source_pick;
  } prc_pwr_type;

  typedef struct packed {
    logic gyro;
    logic accel;
    logic temp;
  } prc_path_type;

  typedef struct packed {
    logic buffer_access_en;
    logic buffer_clear;
    prc_path_type path_clear;
    logic sensor_regs_clear;
    logic regs_default;
    logic sleep_state;
    logic wake_strobe;
    logic sample_strobe;
    logic gyro_drive_on;
    logic gyro_sense_on;
    logic temp_sensor_on;
    logic clk_use_osc;
    logic clk_use_pll;
    logic timing_reset;
  } prc_out_type;

  typedef struct packed {
    logic uc_buf_en;
    logic uc_buf_clr;
    logic uc_path_clr;
    prc_pwr_type pwr;
    logic [1:0] dev_cnt;
    prc_pm_type pm;
    logic pll_meta;
    logic pll_sync;
    logic [7:0] rdata;
    prc_out_type out;
  } prc_state_type;

endpackage

// *** hdl/prc_tick_div.sv ***
`timescale 1ns/1ps
`default_nettype none

module prc_tick_div #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Count control
  input wire logic enable,
  input wire logic [WIDTH-1:0] limit,
  // One-cycle tick every limit+1 enables
  output logic tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } prc_div_state_type;

  prc_div_state_type s;
  prc_div_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (enable) begin
      if (s.count >= limit) begin
        next_s.count = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // prc_tick_div

`default_nettype wire

// *** hdl/prc_power_ctrl.sv ***
// What this block does
// - Buffer enable bit gates serial buffer access
// - Buffer clear bit resets whole buffer asynchronously
// - Buffer clear self-clears after one oscillator cycle
// - Path clear resets gyro, accel, temp paths
// - Path clear also zeroes sensor output registers
// - Reinitialise bit restores all register defaults
// - Reinitialise bit self-clears when reset is done
// - Sleep bit holds the device asleep
// - Cycle bit, with gyro standby off, alternates sleep and one sample
// - All accel axes off: wake, no sample
// - Gyro standby keeps drive, disables sense paths
// - Thermometer off bit disables temperature sensor
// - Codes 0 and 6 pick internal oscillator
// - Codes 1 to 5 pick PLL when ready
// - Code 7 stops clock, holds timing reset
// - Source selector resets to auto-select code
`include "prc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module prc_power_ctrl #(
  parameter int BASE_OSC_TICKS = `PRC_BASE_OSC_TICKS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire prc_pkg::prc_req_type reg_req,
  output logic [7:0] reg_rdata,
  // Surrounding device state
  input wire logic pll_ready,
  input wire logic [7:0] sample_interval_divider,
  input wire logic [2:0] accel_axis_standby,
  // Controls to the sensor core
  output prc_pkg::prc_out_type ctl_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and timebases

  logic [1:0] rst_pipe;
  logic rst_n;
  logic osc_tick;
  logic base_tick;
  logic interval_tick;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // Stands in for the internal 20 MHz oscillator
  prc_tick_div #(.WIDTH(4)) u_osc_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(1'b1),
    .limit(4'(`PRC_OSC_DIV - 1)),
    .tick(osc_tick)
  );

  prc_tick_div #(.WIDTH(15)) u_base_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(osc_tick),
    .limit(15'(BASE_OSC_TICKS - 1)),
    .tick(base_tick)
  );

  // Wake rate of cycle mode follows the sample interval divider
  prc_tick_div #(.WIDTH(8)) u_interval_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(base_tick),
    .limit(sample_interval_divider),
    .tick(interval_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock source decode

  // Returns {use_osc, use_pll, timing_reset}
  function automatic logic [2:0] clk_decode(input logic [2:0] sel,
                                            input logic pll_ok);
    case (sel)
      `PRC_CLK_OSC_A, `PRC_CLK_OSC_B: begin
        clk_decode = 3'h4;
      end
      `PRC_CLK_STOP: begin
        clk_decode = 3'h1;
      end
      default: begin
        clk_decode = pll_ok ? 3'h2 : 3'h4;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  prc_pkg::prc_state_type s;
  prc_pkg::prc_state_type next_s;
  logic wr_uc;
  logic wr_pwr;
  logic rd_uc;
  logic cyc_go;
  logic all_axes_off;

  assign wr_uc = reg_req.wr && !s.pwr.dev_reset &&
                 reg_req.addr == `PRC_USER_CONTROL_ADDR;
  assign wr_pwr = reg_req.wr && !s.pwr.dev_reset &&
                  reg_req.addr == `PRC_POWER_CONTROL_ONE_ADDR;
  assign rd_uc = reg_req.rd && reg_req.addr == `PRC_USER_CONTROL_ADDR;
  assign cyc_go = s.pwr.cycle && !s.pwr.sleep && !s.pwr.gyro_standby;
  assign all_axes_off = &accel_axis_standby;

  always_comb begin
    next_s = s;
    // The first stage feeds only the second
    next_s.pll_meta = pll_ready;
    next_s.pll_sync = s.pll_meta;

    // Self-clearing pulses end on the next oscillator cycle
    if (osc_tick) begin
      next_s.uc_buf_clr = 1'b0;
      next_s.uc_path_clr = 1'b0;
    end

    // Register reinitialise runs for a few oscillator cycles
    if (s.pwr.dev_reset && osc_tick) begin
      if (s.dev_cnt == `PRC_DEV_RST_LAST) begin
        next_s.pwr = prc_pkg::prc_pwr_type'(`PRC_PWR_RESET);
        next_s.uc_buf_en = 1'(`PRC_UC_RESET >> `PRC_UC_BUF_EN_BIT);
        next_s.uc_buf_clr = 1'b0;
        next_s.uc_path_clr = 1'b0;
        next_s.dev_cnt = 2'h0;
      end else begin
        next_s.dev_cnt = s.dev_cnt + 2'h1;
      end
    end

    // Writes come after the clears so a new set is never lost
    if (wr_uc) begin
      next_s.uc_buf_en = reg_req.wdata[`PRC_UC_BUF_EN_BIT];
      if (reg_req.wdata[`PRC_UC_BUF_CLR_BIT]) begin
        next_s.uc_buf_clr = 1'b1;
      end
      if (reg_req.wdata[`PRC_UC_PATH_CLR_BIT]) begin
        next_s.uc_path_clr = 1'b1;
      end
    end
    if (wr_pwr) begin
      next_s.pwr = prc_pkg::prc_pwr_type'(reg_req.wdata);
      next_s.dev_cnt = 2'h0;
    end

    // Read data, reserved bits forced low
    if (reg_req.rd) begin
      case (reg_req.addr)
        `PRC_USER_CONTROL_ADDR: begin
          next_s.rdata = {1'b0, s.uc_buf_en, 3'h0, s.uc_buf_clr, 1'b0,
                          s.uc_path_clr};
        end
        `PRC_POWER_CONTROL_ONE_ADDR: begin
          next_s.rdata = s.pwr;
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // Power mode; sleep outranks cycling
    case (s.pm)
      prc_pkg::PM_AWAKE: begin
        if (s.pwr.sleep) begin
          next_s.pm = prc_pkg::PM_SLEEP;
        end else if (cyc_go) begin
          next_s.pm = prc_pkg::PM_DOZE;
        end
      end
      prc_pkg::PM_SLEEP: begin
        if (!s.pwr.sleep) begin
          next_s.pm = cyc_go ? prc_pkg::PM_DOZE : prc_pkg::PM_AWAKE;
        end
      end
      prc_pkg::PM_DOZE: begin
        if (s.pwr.sleep) begin
          next_s.pm = prc_pkg::PM_SLEEP;
        end else if (!cyc_go) begin
          next_s.pm = prc_pkg::PM_AWAKE;
        end else if (interval_tick) begin
          next_s.pm = prc_pkg::PM_WAKE;
        end
      end
      prc_pkg::PM_WAKE: begin
        next_s.pm = prc_pkg::PM_DOZE;
      end
      default: begin
        next_s.pm = prc_pkg::PM_AWAKE;
      end
    endcase

    // Outputs are registered copies of the next state
    next_s.out.buffer_access_en = next_s.uc_buf_en;
    next_s.out.buffer_clear = next_s.uc_buf_clr;
    next_s.out.path_clear = {3{next_s.uc_path_clr}};
    next_s.out.sensor_regs_clear = next_s.uc_path_clr;
    next_s.out.regs_default = next_s.pwr.dev_reset;
    next_s.out.sleep_state = next_s.pm == prc_pkg::PM_SLEEP ||
                             next_s.pm == prc_pkg::PM_DOZE;
    next_s.out.wake_strobe = next_s.pm == prc_pkg::PM_WAKE;
    next_s.out.sample_strobe = next_s.pm == prc_pkg::PM_WAKE &&
                               !all_axes_off;
    next_s.out.gyro_drive_on = next_s.pm == prc_pkg::PM_AWAKE;
    next_s.out.gyro_sense_on = next_s.pm == prc_pkg::PM_AWAKE &&
                               !next_s.pwr.gyro_standby;
    next_s.out.temp_sensor_on = !next_s.pwr.thermometer_off &&
                                next_s.pm != prc_pkg::PM_SLEEP;
    {next_s.out.clk_use_osc, next_s.out.clk_use_pll,
     next_s.out.timing_reset} =
      clk_decode(next_s.pwr.timebase_source_pick, next_s.pll_sync);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.pwr <= prc_pkg::prc_pwr_type'(`PRC_PWR_RESET);
      s.out.gyro_drive_on <= 1'b1;
      s.out.gyro_sense_on <= 1'b1;
      s.out.temp_sensor_on <= 1'b1;
      s.out.clk_use_osc <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign ctl_out = s.out;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_uc_write;
    wr_uc;
  endsequence

  sequence s_doze_tick;
    s.pm == prc_pkg::PM_DOZE && interval_tick && cyc_go;
  endsequence

  a_buf_en_follow: assert property (
    s_uc_write |=> ctl_out.buffer_access_en == $past(reg_req.wdata[6]))
    else $error("buffer enable did not follow write");

  a_buf_clr_set: assert property (
    s_uc_write ##0 reg_req.wdata[2] |=> ctl_out.buffer_clear)
    else $error("buffer clear not raised");

  a_buf_clr_end: assert property (
    $rose(ctl_out.buffer_clear) |-> ##[1:11] !ctl_out.buffer_clear)
    else $error("buffer clear held too long");

  a_path_clr_all: assert property (
    s_uc_write ##0 reg_req.wdata[0] |=>
      ctl_out.path_clear == 3'h7 && ctl_out.sensor_regs_clear)
    else $error("path clear incomplete");

  a_regs_clr_tie: assert property (
    ctl_out.sensor_regs_clear == (ctl_out.path_clear == 3'h7))
    else $error("sensor registers clear apart from paths");

  a_dev_rst_done: assert property (
    $rose(ctl_out.regs_default) |-> ##[1:40] !ctl_out.regs_default)
    else $error("reinitialise never finished");

  a_dev_defaults: assert property (
    $fell(ctl_out.regs_default) && !$past(wr_pwr) |->
      s.pwr == prc_pkg::prc_pwr_type'(`PRC_PWR_RESET) &&
      !ctl_out.buffer_access_en)
    else $error("defaults not restored");

  a_sleep_enter: assert property (
    wr_pwr ##0 reg_req.wdata[6] ##1 !wr_pwr |=> ctl_out.sleep_state)
    else $error("sleep not entered");

  a_cycle_wake: assert property (
    s_doze_tick ##0 !s.pwr.sleep |=>
      ctl_out.wake_strobe ##1 !ctl_out.wake_strobe)
    else $error("cycle wake missing");

  a_idle_wake: assert property (
    ctl_out.wake_strobe && $past(all_axes_off) |-> !ctl_out.sample_strobe)
    else $error("sample taken with all axes off");

  a_gyro_stby: assert property (
    s.pwr.gyro_standby && s.pm == prc_pkg::PM_AWAKE |->
      ctl_out.gyro_drive_on && !ctl_out.gyro_sense_on)
    else $error("gyro standby wrong");

  a_temp_off: assert property (
    s.pwr.thermometer_off |-> !ctl_out.temp_sensor_on)
    else $error("temperature sensor still on");

  a_clk_osc: assert property (
    s.pwr.timebase_source_pick == 3'h0 ||
    s.pwr.timebase_source_pick == 3'h6 |->
      ctl_out.clk_use_osc && !ctl_out.clk_use_pll)
    else $error("oscillator code not honoured");

  a_clk_auto: assert property (
    s.pwr.timebase_source_pick inside {[3'h1:3'h5]} |->
      ctl_out.clk_use_pll == s.pll_sync &&
      ctl_out.clk_use_osc == !s.pll_sync)
    else $error("auto select wrong");

  a_clk_stop: assert property (
    s.pwr.timebase_source_pick == 3'h7 |->
      ctl_out.timing_reset && !ctl_out.clk_use_osc && !ctl_out.clk_use_pll)
    else $error("stop code not honoured");

  a_clk_default: assert property (
    $rose(rst_n) |-> s.pwr.timebase_source_pick == 3'h1)
    else $error("selector not auto after reset");

  a_reserved_zero: assert property (
    rd_uc |=> (reg_rdata & 8'hba) == 8'h00)
    else $error("reserved bits read nonzero");

endmodule // prc_power_ctrl

`default_nettype wire

// *** verif/power_reset_clock_control_tb.sv ***
`include "prc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module power_reset_clock_control_tb;
  // Short base period keeps the cycle-mode run brief
  localparam int BASE_TICKS = 4;
  localparam int WAKE_GAP = 2 * BASE_TICKS * `PRC_OSC_DIV;
  localparam int TIME_LIMIT = 20000;

  logic mclk;
  logic nrst;
  prc_pkg::prc_req_type reg_req;
  logic [7:0] reg_rdata;
  logic pll_ready;
  logic [7:0] sample_interval_divider;
  logic [2:0] accel_axis_standby;
  prc_pkg::prc_out_type ctl_out;
  int num_errors;
  int checked;
  int cycles;
  int wakes;
  int samples;
  int exp_wakes;
  logic counting;
  logic [7:0] rd_val;

  prc_power_ctrl #(.BASE_OSC_TICKS(BASE_TICKS)) prc_power_ctrl_i (
    .mclk(mclk),
    .nrst(nrst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .pll_ready(pll_ready),
    .sample_interval_divider(sample_interval_divider),
    .accel_axis_standby(accel_axis_standby),
    .ctl_out(ctl_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Registered strobes are sampled on the edge, before they update
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (counting && ctl_out.wake_strobe === 1'b1) wakes <= wakes + 1;
    if (counting && ctl_out.sample_strobe === 1'b1) samples <= samples + 1;
    if (cycles == TIME_LIMIT) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [6:0] addr, input logic [7:0] data);
    @(posedge mclk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= addr;
    reg_req.wdata <= data;
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask

  // No acknowledge: data is fixed one cycle after the read is taken
  task automatic rd_reg(input logic [6:0] addr);
    @(posedge mclk);
    reg_req.rd <= 1'b1;
    reg_req.addr <= addr;
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    @(posedge mclk);
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_req = '0;
    pll_ready = 1'b0;
    sample_interval_divider = 8'h01;
    accel_axis_standby = 3'h0;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    wakes = 0;
    samples = 0;
    counting = 1'b0;
    rd_val = 8'h00;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    settle(3);
    // Defaults and fallback while the PLL is not ready
    check("osc before pll", {7'h0, ctl_out.clk_use_osc}, 8'h01);
    rd_reg(`PRC_POWER_CONTROL_ONE_ADDR);
    check("pwr reset", rd_val, `PRC_PWR_RESET);
    rd_reg(`PRC_USER_CONTROL_ADDR);
    check("uc reset", rd_val, `PRC_UC_RESET);
    rd_reg(7'h10);
    check("unmapped read", rd_val, 8'h00);
    pll_ready <= 1'b1;
    settle(6);
    check("auto pll", {7'h0, ctl_out.clk_use_pll}, 8'h01);
    // Buffer and path clears pulse, then self-clear
    wr_reg(`PRC_USER_CONTROL_ADDR, 8'hff);
    // Look right away: the next oscillator tick may already end the pulse
    settle(0);
    check("buf enable", {7'h0, ctl_out.buffer_access_en}, 8'h01);
    check("buf clear", {7'h0, ctl_out.buffer_clear}, 8'h01);
    check("path clear", {5'h0, ctl_out.path_clear}, 8'h07);
    check("regs clear", {7'h0, ctl_out.sensor_regs_clear}, 8'h01);
    settle(`PRC_OSC_DIV + 1);
    check("buf clear end", {7'h0, ctl_out.buffer_clear}, 8'h00);
    rd_reg(`PRC_USER_CONTROL_ADDR);
    check("uc readback", rd_val, 8'h40);
    wr_reg(`PRC_USER_CONTROL_ADDR, 8'h00);
    settle(1);
    check("buf disable", {7'h0, ctl_out.buffer_access_en}, 8'h00);
    // Every selector code with the PLL ready
    for (int c = 0; c < 8; c++) begin
      wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'(c));
      settle(3);
      check("clock decode", {5'h0, ctl_out.clk_use_osc, ctl_out.clk_use_pll,
            ctl_out.timing_reset}, (c == 0 || c == 6) ? 8'h04 :
            (c == 7) ? 8'h01 : 8'h02);
    end
    // Thermometer off and gyro standby
    wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'h19);
    settle(3);
    check("temp off", {7'h0, ctl_out.temp_sensor_on}, 8'h00);
    check("gyro standby", {6'h0, ctl_out.gyro_drive_on,
          ctl_out.gyro_sense_on}, 8'h02);
    wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'h41);
    settle(3);
    check("sleep", {7'h0, ctl_out.sleep_state}, 8'h01);
    settle(WAKE_GAP * 2);
    check("no wake asleep", {7'h0, ctl_out.sleep_state}, 8'h01);
    // Cycle mode with accel axes on, then all off
    for (int k = 0; k < 2; k++) begin
      accel_axis_standby <= (k == 0) ? 3'h0 : 3'h7;
      sample_interval_divider <= 8'(k);
      exp_wakes = (WAKE_GAP * 5) / ((k + 1) * BASE_TICKS * `PRC_OSC_DIV);
      wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'h21);
      settle(3);
      check("doze", {7'h0, ctl_out.sleep_state}, 8'h01);
      wakes = 0;
      samples = 0;
      counting = 1'b1;
      settle(WAKE_GAP * 5);
      counting = 1'b0;
      check("wake count", {7'h0, wakes >= exp_wakes - 1 &&
            wakes <= exp_wakes + 1}, 8'h01);
      check("sample count", 8'(samples),
            (k == 0) ? 8'(wakes) : 8'h00);
      wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'h01);
    end
    // Reinitialise restores defaults and clears itself
    wr_reg(`PRC_USER_CONTROL_ADDR, 8'h40);
    wr_reg(`PRC_POWER_CONTROL_ONE_ADDR, 8'h88);
    settle(1);
    check("reinit busy", {7'h0, ctl_out.regs_default}, 8'h01);
    for (int w = 0; w < 40 && ctl_out.regs_default !== 1'b0; w++) settle(1);
    check("reinit done", {7'h0, ctl_out.regs_default}, 8'h00);
    rd_reg(`PRC_POWER_CONTROL_ONE_ADDR);
    check("pwr default", rd_val, `PRC_PWR_RESET);
    rd_reg(`PRC_USER_CONTROL_ADDR);
    check("uc default", rd_val, `PRC_UC_RESET);
    settle(2);
    check("temp back on", {7'h0, ctl_out.temp_sensor_on}, 8'h01);
    test_done();
  end
endmodule // power_reset_clock_control_tb

`default_nettype wire
